/* hdl/thl_pkg.sv */
// Shared constants and types for the limit timer mode control.
// Assumes a single system clock; the timer clock is the prescaler tick.
package thl_pkg;

   // Widths of the count, prescaler, postscaler, source select and mode field.
   localparam int CNT_W  = 8;
   localparam int PRE_W  = 7;
   localparam int POST_W = 4;
   localparam int SRC_W  = 3;
   localparam int MODE_W = 5;

   // Mode field layout: family in the upper bits, variant in the lower.
   localparam int MODE_FAM_HI = 4;
   localparam int MODE_FAM_LO = 3;
   localparam int MODE_VAR_HI = 2;

   // Mode families.
   localparam logic [1:0] FAM_FREE = 2'h0;
   localparam logic [1:0] FAM_ONE  = 2'h1;
   localparam logic [1:0] FAM_MONO = 2'h2;
   localparam logic [1:0] FAM_RSVD = 2'h3;

   // Variants.
   localparam logic [2:0] VAR_0 = 3'h0;
   localparam logic [2:0] VAR_1 = 3'h1;
   localparam logic [2:0] VAR_2 = 3'h2;
   localparam logic [2:0] VAR_3 = 3'h3;
   localparam logic [2:0] VAR_4 = 3'h4;
   localparam logic [2:0] VAR_5 = 3'h5;
   localparam logic [2:0] VAR_6 = 3'h6;
   localparam logic [2:0] VAR_7 = 3'h7;

   // Reset values.
   localparam logic [CNT_W-1:0]  COUNT_RST = 8'h00;
   localparam logic [PRE_W-1:0]  PRE_RST   = 7'h00;
   localparam logic [POST_W-1:0] POST_RST  = 4'h0;

   // Timing in timer clocks that the trigger source must honour.
   localparam int TRIG_SPACING_CLK = 6;
   localparam int LEVEL_HOLD_CLK   = 3;

   // Sequencer state for started modes.
   typedef enum logic {
      THL_WAIT,
      THL_RUN
   } thl_state_t;

endpackage

/* hdl/thl_timer.sv */
// Mode control of an 8-bit period timer with hardware limit.
// Assumes inputs synchronous to i_sys_clk; software strobes are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - One external signal, picked by a source select, starts, stops or resets.
// - Five-bit mode: upper two bits family, lower three bits variant.
// - Debug freeze makes the timer ignore the external signal.
// - Mode 00000 counts while on, holds while off.
// - Free modes: on period match, clear and keep counting.
// - Mode 00001 counts while on and external signal high.
// - Mode 00010 counts while on and external signal low.
// - Free 011/100/101 clear count on any, rising or falling edge.
// - Free 110/111 hold count cleared on low or high level.
// - One-shot 000 starts as soon as on is set.
// - One-shot match clears on bit and stops at zero.
// - One-shot 001/010/011 start on rising, falling or any edge.
// - After on was off, a fresh edge is needed to restart.
// - Monostable match stops at zero, on bit kept for retrigger.
// - Period interrupt at postscaler match, gated by interrupt enable.
// - On bit and external signal pass two synchronising stages.
// - Count write, control write, reset or external reset clear scalers.
module thl_timer
   import thl_pkg::*;
(
   // Clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_rst_n,
   // Control and configuration
   input  wire logic              i_ctrl_wr,
   input  wire logic              i_ctrl_on,
   input  wire logic [2:0]        i_prescale_select,
   input  wire logic [POST_W-1:0] i_postscale_select,
   input  wire logic [MODE_W-1:0] i_limit_timer_control,
   input  wire logic [SRC_W-1:0]  i_ext_reset_source_select,
   input  wire logic              i_timer_irq_enable,
   input  wire logic              i_debug_freeze,
   // Count and period
   input  wire logic              i_count_wr,
   input  wire logic [CNT_W-1:0]  i_count_wdata,
   input  wire logic [CNT_W-1:0]  i_period_value,
   // External reset sources
   input  wire logic [7:0]        i_external_reset_input,
   // Status
   output logic [CNT_W-1:0]       o_timer_count,
   output logic                   o_on,
   output logic                   o_postscaled,
   output logic                   o_timer_irq
);

   function automatic logic is_reserved(input logic [MODE_W-1:0] m);
      logic [1:0] f;
      logic [2:0] v;
      f = m[MODE_FAM_HI:MODE_FAM_LO];
      v = m[MODE_VAR_HI:0];
      return (f == FAM_RSVD) ||
             (f == FAM_MONO && (v == VAR_0 || v == VAR_4 || v == VAR_5));
   endfunction

   logic [CNT_W-1:0]  count_r;
   logic              on_r;
   logic              on_q1_r;
   logic              on_q2_r;
   logic              ers_s1_r;
   logic              ers_s2_r;
   logic              ers_lvl_r;
   logic              ers_prev_r;
   logic              rise_p_r;
   logic              fall_p_r;
   logic [PRE_W-1:0]  pre_r;
   logic [POST_W-1:0] post_r;
   thl_state_t        state_r;

   logic [1:0]        fam;
   logic [2:0]        vsel;
   logic              rsvd;
   logic              on_act;
   logic              ext_sel;
   logic              rise_e;
   logic              fall_e;
   logic              tick;
   logic [PRE_W-1:0]  pre_mask;
   logic              gate;
   logic              start;
   logic              rst_evt;
   logic              run;
   logic              match;
   logic              post_hit;
   logic              scl_clr;

   assign fam      = i_limit_timer_control[MODE_FAM_HI:MODE_FAM_LO];
   assign vsel     = i_limit_timer_control[MODE_VAR_HI:0];
   assign rsvd     = is_reserved(i_limit_timer_control);
   assign on_act   = on_r && on_q2_r;
   assign ext_sel  = i_external_reset_input[i_ext_reset_source_select];
   assign rise_e   = rise_p_r || (ers_lvl_r && !ers_prev_r);
   assign fall_e   = fall_p_r || (!ers_lvl_r && ers_prev_r);
   assign pre_mask = PRE_W'((8'h01 << i_prescale_select) - 8'h01);
   assign tick     = on_act && (pre_r == pre_mask);
   assign match    = (count_r == i_period_value);

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ers_s1_r <= 1'b0;
         ers_s2_r <= 1'b0;
         on_q1_r  <= 1'b0;
         on_q2_r  <= 1'b0;
      end else begin
         ers_s1_r <= ext_sel;
         ers_s2_r <= ers_s1_r;
         on_q1_r  <= on_r;
         on_q2_r  <= on_q1_r;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ers_lvl_r  <= 1'b0;
         ers_prev_r <= 1'b0;
      end else if (!i_debug_freeze) begin
         ers_lvl_r  <= ers_s2_r;
         ers_prev_r <= ers_lvl_r;
      end
   end

   // Edges are held until the next timer tick, so a slow prescale misses none.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rise_p_r <= 1'b0;
         fall_p_r <= 1'b0;
      end else if (tick || !on_act) begin
         rise_p_r <= 1'b0;
         fall_p_r <= 1'b0;
      end else begin
         rise_p_r <= rise_e;
         fall_p_r <= fall_e;
      end
   end

   always_comb begin
      gate    = 1'b0;
      start   = 1'b0;
      rst_evt = 1'b0;
      unique case (fam)
         FAM_FREE: begin
            gate = 1'b1;
            unique case (vsel)
               VAR_0: gate = 1'b1;
               VAR_1: gate = ers_lvl_r;
               VAR_2: gate = !ers_lvl_r;
               VAR_3: rst_evt = rise_e || fall_e;
               VAR_4: rst_evt = rise_e;
               VAR_5: rst_evt = fall_e;
               VAR_6: rst_evt = !ers_lvl_r;
               VAR_7: rst_evt = ers_lvl_r;
            endcase
         end
         FAM_ONE: begin
            unique case (vsel)
               VAR_0: start = 1'b1;
               VAR_1: start = rise_e;
               VAR_2: start = fall_e;
               VAR_3: start = rise_e || fall_e;
               VAR_4: begin
                  start   = rise_e;
                  rst_evt = rise_e;
               end
               VAR_5: begin
                  start   = fall_e;
                  rst_evt = fall_e;
               end
               VAR_6: begin
                  start   = rise_e;
                  rst_evt = !ers_lvl_r;
               end
               VAR_7: begin
                  start   = fall_e;
                  rst_evt = ers_lvl_r;
               end
            endcase
         end
         FAM_MONO: begin
            unique case (vsel)
               VAR_1: start = rise_e;
               VAR_2: start = fall_e;
               VAR_3: start = rise_e || fall_e;
               VAR_6: begin
                  start   = ers_lvl_r;
                  rst_evt = !ers_lvl_r;
               end
               VAR_7: begin
                  start   = !ers_lvl_r;
                  rst_evt = ers_lvl_r;
               end
               default: start = 1'b0;
            endcase
         end
         FAM_RSVD: start = 1'b0;
      endcase
   end

   assign run = tick && !rsvd &&
                ((fam == FAM_FREE) ? gate : (state_r == THL_RUN || start));
   assign post_hit = run && !rst_evt && match && (post_r == i_postscale_select);
   assign scl_clr  = i_count_wr || i_ctrl_wr || (run && rst_evt);

   // Count, on bit and start sequencer.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_r <= COUNT_RST;
         on_r    <= 1'b0;
         state_r <= THL_WAIT;
      end else begin
         // A software write of the on bit wins over the hardware clear.
         if (i_ctrl_wr) begin
            on_r <= i_ctrl_on;
         end
         // Losing the on bit re-arms the start condition.
         if (!on_act) begin
            state_r <= THL_WAIT;
         end
         if (i_count_wr) begin
            count_r <= i_count_wdata;
         end else if (run) begin
            if (fam != FAM_FREE) begin
               state_r <= THL_RUN;
            end
            if (rst_evt) begin
               count_r <= COUNT_RST;
            end else if (match) begin
               count_r <= COUNT_RST;
               if (fam == FAM_ONE) begin
                  state_r <= THL_WAIT;
                  if (!i_ctrl_wr) begin
                     on_r <= 1'b0;
                  end
               end
               if (fam == FAM_MONO) begin
                  state_r <= THL_WAIT;
               end
            end else begin
               count_r <= count_r + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_r  <= PRE_RST;
         post_r <= POST_RST;
      end else if (scl_clr) begin
         pre_r  <= PRE_RST;
         post_r <= POST_RST;
      end else begin
         pre_r <= (tick || !on_act) ? PRE_RST : pre_r + 7'h01;
         if (post_hit) begin
            post_r <= POST_RST;
         end else if (run && match) begin
            post_r <= post_r + 4'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_postscaled <= 1'b0;
         o_timer_irq  <= 1'b0;
      end else begin
         o_postscaled <= post_hit;
         o_timer_irq  <= post_hit && i_timer_irq_enable;
      end
   end

   assign o_timer_count = count_r;
   assign o_on          = on_r;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_end_of_period;
      run && !rst_evt && match && !i_count_wr && !i_ctrl_wr;
   endsequence

   property p_freeze_ignore;
      i_debug_freeze |=> $stable(ers_lvl_r);
   endproperty
   a_freeze_ignore: assert property (p_freeze_ignore)
      else $error("external level moved during debug freeze");

   property p_sync_delay;
      $rose(ers_lvl_r) |-> $past(ext_sel, 3);
   endproperty
   a_sync_delay: assert property (p_sync_delay)
      else $error("external level rose without three-cycle history");

   property p_oneshot_end;
      (fam == FAM_ONE) ##0 s_end_of_period |=> !on_r && count_r == COUNT_RST;
   endproperty
   a_oneshot_end: assert property (p_oneshot_end)
      else $error("one-shot did not stop and clear on at match");

   property p_mono_end;
      (fam == FAM_MONO) ##0 s_end_of_period |=>
         on_r && count_r == COUNT_RST && state_r == THL_WAIT;
   endproperty
   a_mono_end: assert property (p_mono_end)
      else $error("monostable did not keep on and stop at match");

   property p_free_wrap;
      (fam == FAM_FREE) ##0 s_end_of_period |=> count_r == COUNT_RST && on_r;
   endproperty
   a_free_wrap: assert property (p_free_wrap)
      else $error("free mode did not wrap to zero");

   property p_sw_gate_hold;
      (i_limit_timer_control == 5'h00 && !on_act && !i_count_wr) |=> $stable(count_r);
   endproperty
   a_sw_gate_hold: assert property (p_sw_gate_hold)
      else $error("count moved with on bit clear");

   property p_hw_gate_hold;
      (i_limit_timer_control == 5'h01 && !ers_lvl_r && !i_count_wr) |=> $stable(count_r);
   endproperty
   a_hw_gate_hold: assert property (p_hw_gate_hold)
      else $error("count moved with high gate low");

   property p_reserved_stop;
      (rsvd && !i_count_wr) |=> $stable(count_r);
   endproperty
   a_reserved_stop: assert property (p_reserved_stop)
      else $error("count moved in a reserved mode");

   property p_irq_gate;
      o_timer_irq |-> o_postscaled && $past(i_timer_irq_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("interrupt without postscaled pulse and enable");

   property p_scaler_clear;
      i_count_wr |=> pre_r == PRE_RST && post_r == POST_RST;
   endproperty
   a_scaler_clear: assert property (p_scaler_clear)
      else $error("count write did not clear the scalers");

endmodule

`default_nettype wire

/* verif/thl_ext_src.sv */
// Model of the peripheral that drives the external reset signals.
// Assumes prescale 1:1, so each system clock is one timer clock.
`timescale 1ns/10ps
`default_nettype none
module thl_ext_src
   import thl_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // Requested level and selected source
   input  wire logic       i_want,
   input  wire logic [2:0] i_sel,
   // Candidate external signals
   output logic [7:0]      o_ext
);
   logic       lvl_r;
   logic [7:0] alt_r;
   int         gap_r;

   // spaced level changes
   // A change waits six timer clocks, which also keeps every level three.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lvl_r <= 1'b0;
         gap_r <= 0;
      end else if (i_want != lvl_r && gap_r >= TRIG_SPACING_CLK &&
                   gap_r >= LEVEL_HOLD_CLK) begin
         lvl_r <= i_want;
         gap_r <= 0;
      end else if (gap_r < 1000) begin
         gap_r <= gap_r + 1;
      end
   end

   // Unselected sources toggle each cycle, so a wrong pick shows at once.
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         alt_r <= 8'h55;
      end else begin
         alt_r <= ~alt_r;
      end
   end

   always_comb begin
      o_ext = alt_r;
      o_ext[i_sel] = lvl_r;
   end
endmodule
`default_nettype wire

/* verif/tb_thl_timer.sv */
// Bench for the limit timer mode control, driven through its own ports.
// Assumes prescale 1:1, so each system clock is one timer clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
   checked++; \
   if ((e) !== (g)) begin \
      n_mismatch++; \
      $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
   end \
end
module tb_thl_timer
   import thl_pkg::*;
   ;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       cwr = 1'b0;
   logic       con = 1'b0;
   logic [3:0] pscl = 4'h0;
   logic [4:0] mode = 5'h00;
   logic       ien = 1'b1;
   logic       frz = 1'b0;
   logic       nwr = 1'b0;
   logic [7:0] per = 8'h04;
   logic       want = 1'b0;
   logic [7:0] ext_in;
   logic [7:0] cnt;
   logic       on;
   logic       post;
   logic       irq;
   logic [4:0] rsv [5] = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1f};
   int         n_mismatch = 0;
   int         checked = 0;
   int         waited;

   always #2 clk = ~clk;

   thl_timer u_thl_timer (
      .i_sys_clk(clk),
      .i_rst_n(rst_n),
      .i_ctrl_wr(cwr),
      .i_ctrl_on(con),
      .i_prescale_select(3'h0),
      .i_postscale_select(pscl),
      .i_limit_timer_control(mode),
      .i_ext_reset_source_select(3'h5),
      .i_timer_irq_enable(ien),
      .i_debug_freeze(frz),
      .i_count_wr(nwr),
      .i_count_wdata(8'h00),
      .i_period_value(per),
      .i_external_reset_input(ext_in),
      .o_timer_count(cnt),
      .o_on(on),
      .o_postscaled(post),
      .o_timer_irq(irq)
   );

   thl_ext_src u_thl_ext_src (
      .i_sys_clk(clk),
      .i_rst_n(rst_n),
      .i_want(want),
      .i_sel(3'h5),
      .o_ext(ext_in)
   );

   task automatic close_out();
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic ctl(input logic [4:0] md, input logic v);
      @(posedge clk);
      mode <= md;
      con <= v;
      cwr <= 1'b1;
      @(posedge clk);
      cwr <= 1'b0;
   endtask

   // The source model needs time to honour its spacing before the next step.
   task automatic ext(input logic v);
      @(posedge clk);
      want <= v;
      repeat (10) @(posedge clk);
      // Ending off the edge keeps checks that follow away from the update race.
      @(negedge clk);
   endtask

   task automatic start(input logic [4:0] md, input logic v);
      ext(v);
      ctl(md, 1'b0);
      @(posedge clk);
      nwr <= 1'b1;
      @(posedge clk);
      nwr <= 1'b0;
      ctl(md, 1'b1);
   endtask

   task automatic till(input string nm, input int sg, input logic [7:0] v);
      int         i;
      logic [7:0] cur;
      for (i = 0; i < 400; i++) begin
         @(negedge clk);
         cur = (sg == 0) ? cnt : (sg == 1) ? {7'h00, post} : {7'h00, on};
         if (cur === v) break;
      end
      waited = i + 1;
      if (i == 400) begin
         `CHK(nm, 1'b1, 1'b0)
         close_out();
      end
   endtask

   task automatic stay(input string nm, input int n);
      repeat (n) begin
         @(negedge clk);
         `CHK(nm, 8'h00, cnt)
      end
   endtask

   task automatic step_chk(input string nm, input logic run);
      logic [7:0] a;
      @(negedge clk);
      a = cnt;
      @(negedge clk);
      `CHK(nm, run ? ((a == per) ? 8'h00 : a + 8'h01) : a, cnt)
   endtask

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK("count", 8'h00, cnt)
      `CHK("on", 1'b0, on)
      start(5'h00, 1'b0);
      till("count", 0, per);
      @(negedge clk);
      `CHK("wrap", 8'h00, cnt)
      `CHK("post", 1'b1, post)
      `CHK("irq", 1'b1, irq)
      step_chk("run", 1'b1);
      ctl(5'h00, 1'b0);
      step_chk("hold", 1'b0);
      @(posedge clk);
      pscl <= 4'h2;
      ien <= 1'b0;
      ctl(5'h00, 1'b1);
      till("post", 1, 8'h01);
      till("post", 1, 8'h01);
      `CHK("gap", 15, waited)
      `CHK("masked", 1'b0, irq)
      @(posedge clk);
      pscl <= 4'h0;
      ien <= 1'b1;
      for (int m = 1; m <= 2; m++) begin
         start(5'(m), 1'(m == 2));
         step_chk("gate off", 1'b0);
         ext(1'(m != 2));
         step_chk("gate on", 1'b1);
         ext(1'(m == 2));
         step_chk("gate off", 1'b0);
      end
      @(posedge clk);
      per <= 8'hc8;
      for (int v = 3; v <= 5; v++) begin
         start({2'b00, 3'(v)}, 1'b0);
         repeat (20) @(posedge clk);
         ext(1'b1);
         `CHK("rise", 1'(v != 5), cnt < 8'h0c)
         ext(1'b0);
         `CHK("fall", 1'(v != 4), cnt < 8'h0c)
      end
      for (int v = 6; v <= 7; v++) begin
         start({2'b00, 3'(v)}, 1'(v == 6));
         ext(1'(v == 7));
         stay("level", 4);
         ext(1'(v == 6));
         step_chk("level off", 1'b1);
      end
      start(5'h04, 1'b0);
      @(posedge clk);
      frz <= 1'b1;
      repeat (20) @(posedge clk);
      ext(1'b1);
      `CHK("freeze", 1'b0, cnt < 8'h0c)
      @(posedge clk);
      frz <= 1'b0;
      start(5'h0c, 1'b0);
      ext(1'b1);
      repeat (20) @(posedge clk);
      ext(1'b0);
      ext(1'b1);
      `CHK("restart", 1'b1, cnt < 8'h0c)
      @(posedge clk);
      per <= 8'h28;
      start(5'h08, 1'b0);
      till("one end", 2, 8'h00);
      stay("one stop", 4);
      start(5'h09, 1'b0);
      ext(1'b1);
      ctl(5'h09, 1'b0);
      ctl(5'h09, 1'b1);
      step_chk("no edge", 1'b0);
      ext(1'b0);
      ext(1'b1);
      step_chk("edge", 1'b1);
      for (int v = 1; v <= 3; v++) begin
         start({2'b01, 3'(v)}, 1'(v == 2));
         stay("wait", 4);
         ext(1'(v != 2));
         step_chk("started", 1'b1);
         till("one end", 2, 8'h00);
         `CHK("one zero", 8'h00, cnt)
      end
      for (int v = 6; v <= 7; v++) begin
         start({2'b01, 3'(v)}, 1'(v == 7));
         stay("ol wait", 4);
         ext(1'(v == 6));
         step_chk("ol start", 1'b1);
         ext(1'(v == 7));
         stay("ol reset", 4);
         ext(1'(v == 6));
         step_chk("ol run", 1'b1);
      end
      for (int v = 1; v <= 3; v++) begin
         start({2'b10, 3'(v)}, 1'(v == 2));
         stay("mono wait", 4);
         ext(1'(v != 2));
         till("mono", 0, per);
         @(negedge clk);
         `CHK("mono zero", 8'h00, cnt)
         `CHK("mono on", 1'b1, on)
         stay("mono stop", 4);
         ext(1'(v == 2));
         ext(1'(v != 2));
         till("retrigger", 0, per);
      end
      start(5'h16, 1'b1);
      ext(1'b0);
      stay("lvl reset", 4);
      ext(1'b1);
      step_chk("lvl run", 1'b1);
      for (int k = 0; k < 5; k++) begin
         start(rsv[k], 1'b0);
         ext(1'b1);
         ext(1'b0);
         stay("reserved", 3);
      end
      close_out();
   end
endmodule
`default_nettype wire
